/* File: mfp_pkg.sv */
// Purpose: constants, register map and carrier types of the four-channel pwm block
// Assumes: 100 MHz system clock, 32-bit APB register access
// Notes:   all timing counts derive from the named times and rates below
`default_nettype none

package mfp_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int SYS_CLOCK_KHZ   = 100000;
  localparam int CLOCK_KHZ       = 20000;
  localparam int PERIOD_US       = 1000;
  localparam int PERIOD_CLOCKS   = CLOCK_KHZ * PERIOD_US / 1000;
  localparam int DUTY_SCALE      = 254;
  localparam int INTERVAL_COUNT  = PERIOD_CLOCKS / DUTY_SCALE;
  localparam int CLK_DIV         = SYS_CLOCK_KHZ / CLOCK_KHZ;
  localparam int TICK_NS         = 3900;
  localparam int TICK_SYS_CYCLES = TICK_NS * SYS_CLOCK_KHZ / 1000000;

  localparam logic [2:0] DIV_LAST        = 3'(CLK_DIV - 1);
  localparam logic [7:0] INTERVAL_RELOAD = 8'(INTERVAL_COUNT - 1);
  localparam logic [7:0] PERIOD_TICKS    = 8'(DUTY_SCALE);

  //////////////////////////////////////////////////////////////////////////////
  // register map (byte addresses)
  localparam int         ADDR_W         = 12;
  localparam int         TABLE_ENTRIES  = 8;
  localparam int         PTR_W          = 3;
  localparam logic [11:0] CTRL_OFS      = 12'h000;
  localparam logic [11:0] STATUS_OFS    = 12'h004;
  localparam logic [11:0] LAST_OFS      = 12'h008;
  localparam logic [11:0] TABLE_BASE    = 12'h200;
  localparam logic [11:0] TABLE_END     = 12'h220;

  localparam int CTRL_RUN_BIT    = 0;
  localparam int STAT_PTR_LSB    = 0;
  localparam int STAT_OUT_LSB    = 4;
  localparam int STAT_PERIOD_LSB = 8;
  localparam int STAT_RUN_BIT    = 16;

  localparam logic [2:0] LAST_RESET   = 3'h3;
  localparam logic [3:0] OUTPUT_INITIAL_VALUE = 4'h0;

  //////////////////////////////////////////////////////////////////////////////
  // duty step codes in percent
  function automatic logic [7:0] dutyCode(input int pct);
    return 8'((DUTY_SCALE * pct + 50) / 100);
  endfunction : dutyCode

  // channel 0 in the low byte of each entry
  function automatic logic [31:0] tableReset(input int idx);
    unique case (idx)
      0:       return {dutyCode(0),  dutyCode(25), dutyCode(50), dutyCode(100)};
      1:       return {dutyCode(5),  dutyCode(25), dutyCode(50), dutyCode(75)};
      2:       return {dutyCode(90), dutyCode(10), dutyCode(100), dutyCode(0)};
      3:       return {dutyCode(50), dutyCode(50), dutyCode(50), dutyCode(50)};
      default: return 32'h0000_0000;
    endcase
  endfunction : tableReset

  //////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic [ADDR_W-1:0] paddr;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [31:0]       pwdata;
  } mfpApbReq_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } mfpApbRsp_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_ARM  = 3'h2,
    ST_RUN  = 3'h4
  } mfpRunState_type;

endpackage : mfp_pkg

`default_nettype wire

/* File: mfp_pwm_top.sv */
// Purpose: four multiplexed pwm outputs, 254 levels, about 1 ms period, APB control
// Assumes: 100 MHz clk, asynchronous active-low nrst, switch pin active low
// Notes:   the 20 MHz timing clock is an enable pulse from a divider of clk
//
// Summary of operation
// - a base tick is made every 3.9 us and steps all four outputs
// - the tick comes from an 8-bit interval counter
// - on each tick the prepared pattern drives the pins before anything else
// - the pattern for the following tick is computed during the interval
// - after applying, period end is checked; the switch is sampled only then
// - at period end the initial pattern and duty counts are reloaded
// - after a press the current duty set still runs one more period
// - a confirmed press at period end advances the duty table pointer
// - switch history confirms a press and rejects contact chatter
// - the nominal period is 1000 us
// - timing assumes a 20000 kHz logic clock
// - period clocks are kHz times us over 1000; interval is that over 254
// - 254 duty levels; duty gives high time in ticks from 0 to 254
// - duty step codes are (254 times percent plus 50) over 100
// - each table entry holds four duty bytes in one aligned word
// - the duty table starts at address 200H
// - the output pattern register starts at all zeros
// - between ticks the outputs stay unchanged
// - each duty counter counts down per tick; at zero its next bit goes low
// - the period counter ends on the 254th tick; full duty never goes low
// - initial pattern: zero-duty outputs low, all others high
// - the first tick after the interval counter starts is ignored
//
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module mfp_pwm_top (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire mfp_pkg::mfpApbReq_type apbReq,
  output var  mfp_pkg::mfpApbRsp_type apbRsp,
  input  wire logic                   switchInPinN,
  output var  logic [3:0]             pwmOutPins
);
  import mfp_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // declarations
  mfpRunState_type        runState_reg;
  logic [2:0]             divCnt_reg;
  logic                   clkEn_reg;
  logic [7:0]             intvCnt_reg;
  logic                   tickEvt_reg;
  logic                   skipFirst_reg;
  logic                   tickValid;
  logic                   procStage_reg;
  logic [7:0]             periodCnt_reg;
  logic                   periodEnd;
  logic [7:0]             dutyCnt_reg [4];
  logic [3:0]             nextBuf_reg;
  logic [3:0]             initPattern;
  logic [31:0]            stagedCodes_reg;
  logic [2:0]             swSync_reg;
  logic                   swPressed_reg;
  logic [1:0]             swHistory_reg;
  logic                   pressEvt;
  logic [PTR_W-1:0]       nextDutyPointer_reg;
  logic [PTR_W-1:0]       ptrNext;
  logic [PTR_W-1:0]       tableLast_reg;
  logic [31:0]            dutyTable_reg [TABLE_ENTRIES];
  logic                   runBit_reg;
  logic [31:0]            rdData;
  logic                   addrHit;
  logic                   apbWrite;
  logic [PTR_W-1:0]       tableIdx;

  //////////////////////////////////////////////////////////////////////////////
  // 20 MHz enable from the 100 MHz clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      divCnt_reg <= 3'h0;
      clkEn_reg  <= 1'b0;
    end else if (divCnt_reg == DIV_LAST) begin
      divCnt_reg <= 3'h0;
      clkEn_reg  <= 1'b1;
    end else begin
      divCnt_reg <= 3'(divCnt_reg + 3'h1);
      clkEn_reg  <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // run control
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      runState_reg <= ST_IDLE;
    end else begin
      unique case (runState_reg)
        ST_IDLE: if (runBit_reg) runState_reg <= ST_ARM;
        ST_ARM:  runState_reg <= ST_RUN;
        ST_RUN:  if (!runBit_reg) runState_reg <= ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interval counter and tick
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      intvCnt_reg <= 8'h00;
      tickEvt_reg <= 1'b0;
    end else if (runState_reg != ST_RUN) begin
      intvCnt_reg <= INTERVAL_RELOAD;
      tickEvt_reg <= 1'b0;
    end else begin
      tickEvt_reg <= clkEn_reg && (intvCnt_reg == 8'h00);
      if (clkEn_reg) begin
        intvCnt_reg <= (intvCnt_reg == 8'h00) ? INTERVAL_RELOAD : 8'(intvCnt_reg - 8'h01);
      end
    end
  end

  // the first tick after start would come after a partial interval
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      skipFirst_reg <= 1'b0;
    end else if (runState_reg == ST_ARM) begin
      skipFirst_reg <= 1'b1;
    end else if (tickEvt_reg) begin
      skipFirst_reg <= 1'b0;
    end
  end

  // a tick registered in the last run cycle must not step the pins after stop
  assign tickValid = tickEvt_reg && !skipFirst_reg && (runState_reg == ST_RUN);

  // processing runs one cycle after the pins are driven, never before
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      procStage_reg <= 1'b0;
    end else begin
      procStage_reg <= tickValid;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output pins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwmOutPins <= OUTPUT_INITIAL_VALUE;
    end else if (runState_reg == ST_IDLE) begin
      pwmOutPins <= OUTPUT_INITIAL_VALUE;
    end else if (tickValid) begin
      pwmOutPins <= nextBuf_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // period counter
  assign periodEnd = procStage_reg && (periodCnt_reg == 8'h01);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      periodCnt_reg <= 8'h00;
    end else if (runState_reg == ST_ARM) begin
      periodCnt_reg <= PERIOD_TICKS;
    end else if (periodEnd) begin
      periodCnt_reg <= PERIOD_TICKS;
    end else if (procStage_reg) begin
      periodCnt_reg <= 8'(periodCnt_reg - 8'h01);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // per-channel duty counters and next pattern bits
  for (genvar ch = 0; ch < 4; ch++) begin : gChannel
    assign initPattern[ch] = |stagedCodes_reg[ch*8 +: 8];

    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        dutyCnt_reg[ch] <= 8'h00;
      end else if (runState_reg == ST_ARM || periodEnd) begin
        dutyCnt_reg[ch] <= stagedCodes_reg[ch*8 +: 8];
      end else if (procStage_reg && dutyCnt_reg[ch] != 8'h00) begin
        dutyCnt_reg[ch] <= 8'(dutyCnt_reg[ch] - 8'h01);
      end
    end

    // period end wins over the zero crossing, so a full-scale duty stays high
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        nextBuf_reg[ch] <= 1'b0;
      end else if (runState_reg == ST_IDLE) begin
        nextBuf_reg[ch] <= OUTPUT_INITIAL_VALUE[ch];
      end else if (runState_reg == ST_ARM || periodEnd) begin
        nextBuf_reg[ch] <= initPattern[ch];
      end else if (procStage_reg && dutyCnt_reg[ch] == 8'h01) begin
        nextBuf_reg[ch] <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // switch: three-stage synchroniser, then history sampled at period ends
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      swSync_reg    <= 3'h7;
      swPressed_reg <= 1'b0;
    end else begin
      swSync_reg <= {swSync_reg[1:0], switchInPinN};
      if (swSync_reg[1] == swSync_reg[2]) begin
        swPressed_reg <= ~swSync_reg[2];
      end
    end
  end

  // a press must be seen at two period ends in a row after a release
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      swHistory_reg <= 2'h0;
    end else if (periodEnd) begin
      swHistory_reg <= {swHistory_reg[0], swPressed_reg};
    end
  end

  assign pressEvt = periodEnd && ({swHistory_reg, swPressed_reg} == 3'h3);

  //////////////////////////////////////////////////////////////////////////////
  // duty pointer and staged codes
  always_comb begin
    ptrNext = nextDutyPointer_reg;
    if (pressEvt) begin
      if (nextDutyPointer_reg == tableLast_reg) begin
        ptrNext = '0;
      end else begin
        ptrNext = PTR_W'(nextDutyPointer_reg + 1'b1);
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      nextDutyPointer_reg <= '0;
    end else begin
      nextDutyPointer_reg <= ptrNext;
    end
  end

  // staged codes follow the pointer on the same edge; the duty counters lag it by one period
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stagedCodes_reg <= 32'h0000_0000;
    end else if (runState_reg == ST_IDLE) begin
      stagedCodes_reg <= dutyTable_reg[nextDutyPointer_reg];
    end else if (periodEnd) begin
      stagedCodes_reg <= dutyTable_reg[ptrNext];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB slave, one wait state on every access
  assign tableIdx = apbReq.paddr[PTR_W+1:2];
  assign apbWrite = apbReq.psel && apbReq.penable && apbRsp.pready && apbReq.pwrite && addrHit;

  always_comb begin
    rdData  = 32'h0000_0000;
    addrHit = 1'b0;
    if (apbReq.paddr[1:0] == 2'h0) begin
      if (apbReq.paddr == CTRL_OFS) begin
        addrHit               = 1'b1;
        rdData[CTRL_RUN_BIT]  = runBit_reg;
      end else if (apbReq.paddr == STATUS_OFS) begin
        addrHit = 1'b1;
        rdData[STAT_PTR_LSB +: PTR_W]  = nextDutyPointer_reg;
        rdData[STAT_OUT_LSB +: 4]      = pwmOutPins;
        rdData[STAT_PERIOD_LSB +: 8]   = periodCnt_reg;
        rdData[STAT_RUN_BIT]           = (runState_reg == ST_RUN);
      end else if (apbReq.paddr == LAST_OFS) begin
        addrHit              = 1'b1;
        rdData[PTR_W-1:0]    = tableLast_reg;
      end else if (apbReq.paddr >= TABLE_BASE && apbReq.paddr < TABLE_END) begin
        addrHit = 1'b1;
        rdData  = dutyTable_reg[tableIdx];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      apbRsp <= '0;
    end else if (apbReq.psel && apbReq.penable && !apbRsp.pready) begin
      apbRsp.pready  <= 1'b1;
      apbRsp.pslverr <= !addrHit;
      apbRsp.prdata  <= apbReq.pwrite ? 32'h0000_0000 : rdData;
    end else begin
      apbRsp.pready  <= 1'b0;
      apbRsp.pslverr <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      runBit_reg    <= 1'b0;
      tableLast_reg <= LAST_RESET;
    end else if (apbWrite && apbReq.paddr == CTRL_OFS) begin
      runBit_reg <= apbReq.pwdata[CTRL_RUN_BIT];
    end else if (apbWrite && apbReq.paddr == LAST_OFS) begin
      tableLast_reg <= apbReq.pwdata[PTR_W-1:0];
    end
  end

  // table words can be rewritten while running; the change shows at a period end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < TABLE_ENTRIES; i++) begin
        dutyTable_reg[i] <= tableReset(i);
      end
    end else if (apbWrite && apbReq.paddr >= TABLE_BASE && apbReq.paddr < TABLE_END) begin
      dutyTable_reg[tableIdx] <= apbReq.pwdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  logic [15:0] tickGap_reg;
  logic        tickSeen_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tickGap_reg  <= 16'h0000;
      tickSeen_reg <= 1'b0;
    end else if (runState_reg != ST_RUN) begin
      tickGap_reg  <= 16'h0000;
      tickSeen_reg <= 1'b0;
    end else if (tickEvt_reg) begin
      tickGap_reg  <= 16'h0000;
      tickSeen_reg <= 1'b1;
    end else if (tickGap_reg != 16'hFFFF) begin
      tickGap_reg <= 16'(tickGap_reg + 16'h0001);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_tick_spacing: assert property (tickEvt_reg && tickSeen_reg |->
    tickGap_reg == 16'(TICK_SYS_CYCLES - 1))
    else $error("base tick spacing is not 3.9 us");

  a_divider_rate: assert property (clkEn_reg |=> !clkEn_reg [*4] ##1 clkEn_reg)
    else $error("timing enable is not one in five cycles");

  a_pins_apply: assert property (tickValid |=> pwmOutPins == $past(nextBuf_reg))
    else $error("pins did not take the prepared pattern on the tick");

  a_pins_hold: assert property (runState_reg == ST_RUN && !tickValid |=>
    $stable(pwmOutPins))
    else $error("pins changed between ticks");

  a_first_skip: assert property (tickEvt_reg && skipFirst_reg |=>
    $stable(pwmOutPins) && !procStage_reg)
    else $error("first tick after start was not ignored");

  a_period_reload: assert property (periodEnd |=> periodCnt_reg == PERIOD_TICKS &&
    nextBuf_reg == $past(initPattern))
    else $error("period end did not reload count and initial pattern");

  a_duty_clear: assert property (procStage_reg && !periodEnd &&
    dutyCnt_reg[0] == 8'h01 |=> !nextBuf_reg[0] && dutyCnt_reg[0] == 8'h00)
    else $error("channel 0 did not go low when its count ran out");

  a_ptr_wrap: assert property (pressEvt && nextDutyPointer_reg == tableLast_reg |=>
    nextDutyPointer_reg == '0)
    else $error("pointer did not wrap after the last entry");

  a_ptr_hold: assert property (!pressEvt |=> $stable(nextDutyPointer_reg))
    else $error("pointer moved without a confirmed press");

  a_press_delay: assert property (pressEvt |=>
    stagedCodes_reg == dutyTable_reg[nextDutyPointer_reg] &&
    dutyCnt_reg[0] == $past(stagedCodes_reg[7:0]))
    else $error("new duty set was not held back one period");

  c_press: cover property (pressEvt);
  c_wrap: cover property (pressEvt && nextDutyPointer_reg == tableLast_reg);
  c_period: cover property (periodEnd && pwmOutPins[0]);
  c_apb_write: cover property (apbWrite && apbReq.paddr == CTRL_OFS);

endmodule : mfp_pwm_top

`default_nettype wire

/* File: mfp_far_side_model.sv */
// Purpose: far side of the pwm block: push switch with pull-up and the four output loads
// Assumes: switch pulls the pin low while pressed
// Notes:   a bouncing contact flips its level every clock
`timescale 1ns/1ns
`default_nettype none

module mfp_far_side_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        pressCmd,
  input  wire logic        chatterCmd,
  input  wire logic [3:0]  pwmOutPins,
  output var  logic        switchInPinN,
  output var  logic [15:0] stableCycles
);
  logic       bounceReg;
  logic [3:0] lastPinsReg;

  //////////////////////////////////////////////////////////////////////////////
  // switch contact
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bounceReg <= 1'b0;
    end else begin
      bounceReg <= ~bounceReg;
    end
  end

  // released contact rests at the pull-up level
  assign switchInPinN = chatterCmd ? bounceReg : ~pressCmd;

  //////////////////////////////////////////////////////////////////////////////
  // loads: cycles since the pins last moved, saturating
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lastPinsReg  <= 4'h0;
      stableCycles <= 16'h0000;
    end else begin
      lastPinsReg <= pwmOutPins;
      if (pwmOutPins !== lastPinsReg) begin
        stableCycles <= 16'h0000;
      end else if (stableCycles != 16'hFFFF) begin
        stableCycles <= stableCycles + 16'h0001;
      end
    end
  end
endmodule : mfp_far_side_model

`default_nettype wire

/* File: tb_mfp_pwm_top.sv */
// Purpose: self-checking bench of the four-channel pwm block
// Assumes: 100 MHz clk, one wait state on APB
// Notes:   a full period is about 99k clocks, so only its opening ticks are watched
`timescale 1ns/1ns
`default_nettype none

module tb_mfp_pwm_top;
  import mfp_pkg::*;

  `define CHK(a, b) begin compares++; if ((a) !== (b)) begin errCount++; \
    $display("mismatch at %0t: got %h exp %h", $time, (a), (b)); end end

  logic           clk;
  logic           nrst;
  logic           pressCmd;
  logic           chatterCmd;
  mfpApbReq_type  apbReq;
  mfpApbRsp_type  apbRsp;
  logic           switchInPinN;
  logic [3:0]     pwmOutPins;
  logic [15:0]    stableCycles;
  logic [31:0]    rdData;
  logic           slvErr;
  int             errCount;
  int             compares;

  mfp_pwm_top DUT (.clk(clk), .nrst(nrst), .apbReq(apbReq), .apbRsp(apbRsp),
    .switchInPinN(switchInPinN), .pwmOutPins(pwmOutPins));

  mfp_far_side_model farSide (.clk(clk), .nrst(nrst), .pressCmd(pressCmd),
    .chatterCmd(chatterCmd), .pwmOutPins(pwmOutPins), .switchInPinN(switchInPinN),
    .stableCycles(stableCycles));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", compares, errCount);
    if (errCount == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
    int n;
    @(posedge clk);
    apbReq.paddr   <= addr;
    apbReq.pwrite  <= wr;
    apbReq.pwdata  <= wdata;
    apbReq.psel    <= 1'b1;
    apbReq.penable <= 1'b0;
    @(posedge clk);
    apbReq.penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (apbRsp.pready === 1'b1) break;
    end
    if (n == 20) begin
      errCount++;
      complete_run();
    end
    rdData = apbRsp.prdata;
    slvErr = apbRsp.pslverr;
    apbReq.psel    <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask : apb

  function automatic logic [7:0] stepCode(input int pct);
    return 8'((DUTY_SCALE * pct + 50) / 100);
  endfunction : stepCode

  // ch3 in the top byte
  function automatic logic [31:0] resetEntry(input int i);
    case (i)
      0:       return {stepCode(0), stepCode(25), stepCode(50), stepCode(100)};
      1:       return {stepCode(5), stepCode(25), stepCode(50), stepCode(75)};
      2:       return {stepCode(90), stepCode(10), stepCode(100), stepCode(0)};
      3:       return {4{stepCode(50)}};
      default: return 32'h0000_0000;
    endcase
  endfunction : resetEntry

  // bounded wait for the pins to move; returns cycles waited
  task automatic wait_change(input logic [3:0] from, output int m);
    m = 0;
    do begin
      @(posedge clk);
      #1;
      m++;
    end while (pwmOutPins === from && m < 900);
    if (pwmOutPins === from) begin
      errCount++;
      complete_run();
    end
  endtask : wait_change

  //////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic test_reset_values();
    `CHK(pwmOutPins, 4'h0)
    apb(1'b0, CTRL_OFS, 32'h0);
    `CHK(rdData, 32'h0000_0000)
    apb(1'b0, STATUS_OFS, 32'h0);
    `CHK(rdData, 32'h0000_0000)
    apb(1'b0, LAST_OFS, 32'h0);
    `CHK(rdData, 32'h0000_0003)
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, TABLE_BASE + 12'(4 * i), 32'h0);
      `CHK(rdData, resetEntry(i))
    end
    $display("test reset_values done");
  endtask : test_reset_values

  task automatic test_bus_map();
    apb(1'b0, TABLE_END, 32'h0);
    `CHK({slvErr, rdData}, 33'h1_0000_0000)
    apb(1'b1, TABLE_BASE + 12'h001, 32'hFFFF_FFFF);
    `CHK(slvErr, 1'b1)
    apb(1'b0, TABLE_BASE, 32'h0);
    `CHK(rdData, resetEntry(0))
    apb(1'b1, STATUS_OFS, 32'hFFFF_FFFF);
    `CHK(slvErr, 1'b0)
    apb(1'b0, STATUS_OFS, 32'h0);
    `CHK(rdData, 32'h0000_0000)
    apb(1'b1, LAST_OFS, 32'h0000_0005);
    apb(1'b0, LAST_OFS, 32'h0);
    `CHK(rdData, 32'h0000_0005)
    apb(1'b1, LAST_OFS, 32'h0000_0003);
    // ch0 one tick, ch1 two ticks, ch2 never high, ch3 full scale
    apb(1'b1, TABLE_BASE, 32'hFE00_0201);
    apb(1'b0, TABLE_BASE, 32'h0);
    `CHK(rdData, 32'hFE00_0201)
    $display("test bus_map done");
  endtask : test_bus_map

  task automatic test_pwm_run();
    int m;
    chatterCmd <= 1'b1;
    apb(1'b1, CTRL_OFS, 32'h0000_0001);
    wait_change(4'h0, m);
    `CHK((m > 390 && m <= 800), 1'b1)
    `CHK(pwmOutPins, 4'hB)
    wait_change(4'hB, m);
    `CHK(m, 390)
    `CHK(pwmOutPins, 4'hA)
    wait_change(4'hA, m);
    `CHK(m, 390)
    `CHK(pwmOutPins, 4'h8)
    repeat (1600) @(posedge clk);
    `CHK((stableCycles >= 16'h0636), 1'b1)
    apb(1'b0, STATUS_OFS, 32'h0);
    `CHK({rdData[16], rdData[7:4], rdData[2:0]}, 8'hC0)
    chatterCmd <= 1'b0;
    $display("test pwm_run done");
  endtask : test_pwm_run

  task automatic test_stop();
    pressCmd <= 1'b1;
    apb(1'b1, CTRL_OFS, 32'h0);
    repeat (3) @(posedge clk);
    `CHK(pwmOutPins, 4'h0)
    repeat (800) @(posedge clk);
    `CHK((stableCycles >= 16'h0316), 1'b1)
    apb(1'b0, STATUS_OFS, 32'h0);
    `CHK({rdData[16], rdData[2:0]}, 4'h0)
    pressCmd <= 1'b0;
    $display("test stop done");
  endtask : test_stop

  //////////////////////////////////////////////////////////////////////////////
  // main sequence and hang guard
  initial begin
    errCount   = 0;
    compares   = 0;
    nrst       = 1'b0;
    pressCmd   = 1'b0;
    chatterCmd = 1'b0;
    apbReq     = '0;
    repeat (5) @(posedge clk);
    // release just after an edge, like every other input
    nrst <= 1'b1;
    @(posedge clk);
    test_reset_values();
    test_bus_map();
    test_pwm_run();
    test_stop();
    complete_run();
  end

  initial begin
    repeat (20000) @(posedge clk);
    errCount++;
    $display("mismatch at %0t: got %h exp %h", $time, 1'b0, 1'b1);
    complete_run();
  end
endmodule : tb_mfp_pwm_top

`default_nettype wire
